//--- verification/adccc_cal_config_test.sv
// Purpose: self-checking bench of the channel 1 gain low byte and channel 2 config/calibration bank
// Assumes: read data stands only in the cycle after the read strobe; settings outputs lag a write by two edges
// Notes: expected values are built here from the bit layout of the registers
`timescale 1ns/100ps
`include "adccc_regs.svh"

module adccc_cal_config_test
  import adccc_pkg::*;
;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [`ADCCC_ADDR_W-1:0] regAddr = 6'h00;
  logic [15:0] regWrData = 16'h0000;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic [15:0] regRdData;
  adccc_ch2_config_t ch2Cfg;
  adccc_cal_t calWords;
  int errorCnt = 0;
  int cmpCount = 0;
  int cycleCnt = 0;
  logic [15:0] rdVal;
  localparam logic [5:0] ADDRS [6] = '{`ADCCC_OFS_CH1_GAIN_LOW, `ADCCC_OFS_CH2_CONFIG, `ADCCC_OFS_CH2_OFFSET_HIGH,
    `ADCCC_OFS_CH2_OFFSET_LOW, `ADCCC_OFS_CH2_GAIN_HIGH, `ADCCC_OFS_CH2_GAIN_LOW};
  localparam logic [15:0] RSTS [6] = '{`ADCCC_RST_CH1_GAIN_LOW, `ADCCC_RST_CH2_CONFIG, `ADCCC_RST_CH2_OFFSET_HIGH,
    `ADCCC_RST_CH2_OFFSET_LOW, `ADCCC_RST_CH2_GAIN_HIGH, `ADCCC_RST_CH2_GAIN_LOW};
  localparam logic [15:0] CFGS [10] = '{16'h8000, 16'h7fc0, 16'h0020, 16'h0010, 16'h0004, 16'h0008,
    16'h0000, 16'h0001, 16'h0002, 16'h0003};

  adccc_cal_config u_dut (
    .core_clk(core_clk),
    .nrst(nrst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWrStrobe(regWrStrobe),
    .regRdStrobe(regRdStrobe),
    .regRdData(regRdData),
    .ch2Cfg(ch2Cfg),
    .calWords(calWords)
  );

  always #25 core_clk = ~core_clk;

  task automatic giveVerdict();
    $display("comparisons %0d, mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycleCnt <= cycleCnt + 1;
    if (cycleCnt == 2000) begin
      errorCnt++;
      giveVerdict();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic doReset();
    nrst <= 1'b0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge core_clk);
    regWrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge core_clk);
    regRdStrobe <= 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask

  task automatic chkReg(input logic [5:0] a, input logic [15:0] e);
    rd(a, rdVal);
    chk({8'h00, rdVal}, {8'h00, e});
    // the answer lasts one cycle, then the port falls back to zero
    @(negedge core_clk);
    chk({8'h00, regRdData}, 24'h000000);
  endtask

  // let the registered settings outputs catch up with the last write
  task automatic settle();
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // settings layout: phase, sensor source, measure on, invert, input select
  function automatic logic [23:0] expCfg(input logic [15:0] v);
    return {9'h000, v[15:6], v[5], v[4], v[2], v[1:0]};
  endfunction

  initial begin
    doReset();
    for (int i = 0; i < 6; i++) begin
      chkReg(ADDRS[i], RSTS[i]);
    end
    chk({9'h000, ch2Cfg}, 24'h000000);
    chk(calWords.chan2Gain, 24'h800000);
    wr(`ADCCC_OFS_CH2_CONFIG, 16'hffff);
    chkReg(`ADCCC_OFS_CH2_CONFIG, 16'hfff7);
    settle();
    chk({9'h000, ch2Cfg}, 24'h007fff);
    // one field at a time, the reserved bit and every input select code
    for (int i = 0; i < 10; i++) begin
      wr(`ADCCC_OFS_CH2_CONFIG, CFGS[i]);
      chkReg(`ADCCC_OFS_CH2_CONFIG, CFGS[i] & 16'hfff7);
      settle();
      chk({9'h000, ch2Cfg}, expCfg(CFGS[i]));
    end
    wr(`ADCCC_OFS_CH2_OFFSET_HIGH, 16'h1234);
    wr(`ADCCC_OFS_CH2_OFFSET_LOW, 16'habff);
    wr(`ADCCC_OFS_CH2_GAIN_HIGH, 16'hfedc);
    wr(`ADCCC_OFS_CH2_GAIN_LOW, 16'h5aa5);
    wr(`ADCCC_OFS_CH1_GAIN_LOW, 16'hc3ff);
    chkReg(`ADCCC_OFS_CH2_OFFSET_LOW, 16'hab00);
    chkReg(`ADCCC_OFS_CH2_GAIN_LOW, 16'h5a00);
    chkReg(`ADCCC_OFS_CH1_GAIN_LOW, 16'hc300);
    chkReg(`ADCCC_OFS_CH2_OFFSET_HIGH, 16'h1234);
    chkReg(`ADCCC_OFS_CH2_GAIN_HIGH, 16'hfedc);
    settle();
    chk(calWords.chan2Offset, 24'h1234ab);
    chk(calWords.chan2Gain, 24'hfedc5a);
    chk({16'h0000, calWords.chan1GainLowByte}, 24'h0000c3);
    // unmapped places read zero and leave the bank alone
    wr(6'h18, 16'hffff);
    chkReg(6'h18, 16'h0000);
    chkReg(6'h11, 16'h0000);
    chkReg(6'h3f, 16'h0000);
    chkReg(`ADCCC_OFS_CH2_GAIN_HIGH, 16'hfedc);
    // reset in mid-run brings back the defaults
    @(posedge core_clk);
    doReset();
    chkReg(`ADCCC_OFS_CH2_GAIN_HIGH, 16'h8000);
    chkReg(`ADCCC_OFS_CH2_CONFIG, 16'h0000);
    chk(calWords.chan2Gain, 24'h800000);
    giveVerdict();
  end
endmodule

//--- verilog/adc_cal_config.sv
// Purpose: channel 1 gain low byte and channel 2 config / calibration registers
// Assumes: register port synchronous to core_clk, read data valid the cycle after the read strobe
// Notes: unmapped addresses read zero and ignore writes
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
`include "adccc_regs.svh"

module adccc_cal_config
  import adccc_pkg::*;
#(
  parameter int ADDR_W = `ADCCC_ADDR_W
)
(
  // clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // register port
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output logic [15:0] regRdData,
  // settings for the channel logic
  output adccc_ch2_config_t ch2Cfg,
  output adccc_cal_t calWords
);

  // the bank offsets need at least the default index width
  if (ADDR_W < `ADCCC_ADDR_W) begin : g_addr_w_check
    $error("register index narrower than the bank offsets");
  end

  logic [15:0] ch1GainCalLow;
  logic [15:0] ch2Config;
  logic [15:0] ch2OffsetCalHigh;
  logic [15:0] ch2OffsetCalLow;
  logic [15:0] ch2GainCalHigh;
  logic [15:0] ch2GainCalLow;
  logic [15:0] next_regRdData;

  // true when the index selects the given bank offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [`ADCCC_ADDR_W-1:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // true for the three calibration low words
  function automatic logic isLowReg(input logic [ADDR_W-1:0] a);
    isLowReg = hit(a, `ADCCC_OFS_CH1_GAIN_LOW) || hit(a, `ADCCC_OFS_CH2_OFFSET_LOW)
      || hit(a, `ADCCC_OFS_CH2_GAIN_LOW);
  endfunction

  // true for any index that the bank answers
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = isLowReg(a) || hit(a, `ADCCC_OFS_CH2_CONFIG) || hit(a, `ADCCC_OFS_CH2_OFFSET_HIGH)
      || hit(a, `ADCCC_OFS_CH2_GAIN_HIGH);
  endfunction

  // keeps only the writable upper byte of a calibration low word
  function automatic logic [15:0] lowWordMask(input logic [15:0] d);
    lowWordMask = {d[`ADCCC_LOWBYTE_MSB:`ADCCC_LOWBYTE_LSB], 8'h00};
  endfunction

  // clears the reserved config bit so it always reads zero
  function automatic logic [15:0] cfgMask(input logic [15:0] d);
    cfgMask = d;
    cfgMask[`ADCCC_RSVD_BIT] = 1'b0;
  endfunction

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch1GainCalLow <= `ADCCC_RST_CH1_GAIN_LOW;
    end else if (regWrStrobe && hit(regAddr, `ADCCC_OFS_CH1_GAIN_LOW)) begin
      ch1GainCalLow <= lowWordMask(regWrData);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch2Config <= `ADCCC_RST_CH2_CONFIG;
    end else if (regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_CONFIG)) begin
      ch2Config <= cfgMask(regWrData);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch2OffsetCalHigh <= `ADCCC_RST_CH2_OFFSET_HIGH;
    end else if (regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_OFFSET_HIGH)) begin
      ch2OffsetCalHigh <= regWrData;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch2OffsetCalLow <= `ADCCC_RST_CH2_OFFSET_LOW;
    end else if (regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_OFFSET_LOW)) begin
      ch2OffsetCalLow <= lowWordMask(regWrData);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch2GainCalHigh <= `ADCCC_RST_CH2_GAIN_HIGH;
    end else if (regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_GAIN_HIGH)) begin
      ch2GainCalHigh <= regWrData;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch2GainCalLow <= `ADCCC_RST_CH2_GAIN_LOW;
    end else if (regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_GAIN_LOW)) begin
      ch2GainCalLow <= lowWordMask(regWrData);
    end
  end

  // read mux, unmapped indexes answer zero
  always_comb begin
    next_regRdData = 16'h0000;
    if (hit(regAddr, `ADCCC_OFS_CH1_GAIN_LOW)) begin
      next_regRdData = ch1GainCalLow;
    end else if (hit(regAddr, `ADCCC_OFS_CH2_CONFIG)) begin
      next_regRdData = ch2Config;
    end else if (hit(regAddr, `ADCCC_OFS_CH2_OFFSET_HIGH)) begin
      next_regRdData = ch2OffsetCalHigh;
    end else if (hit(regAddr, `ADCCC_OFS_CH2_OFFSET_LOW)) begin
      next_regRdData = ch2OffsetCalLow;
    end else if (hit(regAddr, `ADCCC_OFS_CH2_GAIN_HIGH)) begin
      next_regRdData = ch2GainCalHigh;
    end else if (hit(regAddr, `ADCCC_OFS_CH2_GAIN_LOW)) begin
      next_regRdData = ch2GainCalLow;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      regRdData <= 16'h0000;
    end else if (regRdStrobe) begin
      regRdData <= next_regRdData;
    end else begin
      regRdData <= 16'h0000;
    end
  end

  // settings for the channel logic, registered so outputs leave flip-flops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ch2Cfg <= '0;
    end else begin
      ch2Cfg.chan2PhaseDelay <= ch2Config[`ADCCC_PHASE_MSB:`ADCCC_PHASE_LSB];
      ch2Cfg.tempSensorSource <= ch2Config[`ADCCC_TSSRC_BIT];
      ch2Cfg.tempMeasureOn <= ch2Config[`ADCCC_TSON_BIT];
      ch2Cfg.tempInputInvert <= ch2Config[`ADCCC_TSINV_BIT];
      ch2Cfg.chan2InputSelect <= adccc_input_sel_t'(ch2Config[`ADCCC_MUX_MSB:`ADCCC_MUX_LSB]);
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      calWords <= {`ADCCC_RST_CH2_OFFSET_HIGH, 8'h00, `ADCCC_RST_CH2_GAIN_HIGH, 8'h00, 8'h00};
    end else begin
      calWords.chan2Offset <= {ch2OffsetCalHigh, ch2OffsetCalLow[15:8]};
      calWords.chan2Gain <= {ch2GainCalHigh, ch2GainCalLow[15:8]};
      calWords.chan1GainLowByte <= ch1GainCalLow[15:8];
    end
  end

  // assertions
  sequence s_cfgWrite;
    regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_CONFIG);
  endsequence

  sequence s_cfgRead;
    regRdStrobe && hit(regAddr, `ADCCC_OFS_CH2_CONFIG) && !regWrStrobe;
  endsequence

  sequence s_offsetHighWrite;
    regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_OFFSET_HIGH);
  endsequence

  sequence s_offsetLowWrite;
    regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_OFFSET_LOW);
  endsequence

  sequence s_gainHighWrite;
    regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_GAIN_HIGH);
  endsequence

  sequence s_gainLowWrite;
    regWrStrobe && hit(regAddr, `ADCCC_OFS_CH2_GAIN_LOW);
  endsequence

  sequence s_ch1LowWrite;
    regWrStrobe && hit(regAddr, `ADCCC_OFS_CH1_GAIN_LOW);
  endsequence

  sequence s_lowRead;
    regRdStrobe && isLowReg(regAddr);
  endsequence

  // a config write, a cycle with no write, then a read of the config
  sequence s_cfgWriteThenRead;
    s_cfgWrite ##1 !regWrStrobe ##1 s_cfgRead;
  endsequence

  a_cfg_phase_follow: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgWrite |-> ##2 ch2Cfg.chan2PhaseDelay == $past(regWrData[15:6], 2))
    else $error("phase delay does not follow config write");

  a_ts_source_bit: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgWrite |-> ##2 ch2Cfg.tempSensorSource == $past(regWrData[5], 2))
    else $error("sensor source does not follow bit 5");

  a_ts_enable_bit: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgWrite |-> ##2 ch2Cfg.tempMeasureOn == $past(regWrData[4], 2))
    else $error("measure enable does not follow bit 4");

  a_ts_invert_bit: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgWrite |-> ##2 ch2Cfg.tempInputInvert == $past(regWrData[2], 2))
    else $error("input invert does not follow bit 2");

  a_mux_select_bits: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgWrite |-> ##2 ch2Cfg.chan2InputSelect == $past(regWrData[1:0], 2))
    else $error("input select does not follow bits 1:0");

  a_cfg_rsvd_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgRead |=> regRdData[3] == 1'b0)
    else $error("config reserved bit reads nonzero");

  a_offset_word_join: assert property (@(posedge core_clk) disable iff (!nrst)
    ##1 calWords.chan2Offset == $past({ch2OffsetCalHigh, ch2OffsetCalLow[15:8]}))
    else $error("offset word not assembled from high and low");

  a_offset_high_word: assert property (@(posedge core_clk) disable iff (!nrst)
    s_offsetHighWrite |-> ##2 calWords.chan2Offset[23:8] == $past(regWrData, 2))
    else $error("offset high word does not follow write");

  a_low_rsvd_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    s_lowRead |=> regRdData[7:0] == 8'h00)
    else $error("calibration low register reserved byte reads nonzero");

  a_low_write_mask: assert property (@(posedge core_clk) disable iff (!nrst)
    regWrStrobe && isLowReg(regAddr) |=> ch1GainCalLow[7:0] == 8'h00 && ch2OffsetCalLow[7:0] == 8'h00
      && ch2GainCalLow[7:0] == 8'h00)
    else $error("calibration low register reserved byte took a write");

  a_gain_low_keep: assert property (@(posedge core_clk) disable iff (!nrst)
    s_gainLowWrite |-> ##2 calWords.chan2Gain[7:0] == $past(regWrData[15:8], 2))
    else $error("gain low byte does not follow write");

  a_ch1_gain_low: assert property (@(posedge core_clk) disable iff (!nrst)
    s_ch1LowWrite |-> ##2 calWords.chan1GainLowByte == $past(regWrData[15:8], 2))
    else $error("channel 1 gain low byte does not follow write");

  a_gain_high_rst: assert property (@(posedge core_clk)
    $rose(nrst) |-> ch2GainCalHigh == 16'h8000)
    else $error("gain high not at unity after reset");

  a_gain_word_rst: assert property (@(posedge core_clk)
    $rose(nrst) |-> calWords.chan2Gain == 24'h800000)
    else $error("gain word output not at unity after reset");

  a_cfg_rst_zero: assert property (@(posedge core_clk)
    $rose(nrst) |-> ch2Config == 16'h0000)
    else $error("config not zero after reset");

  a_cfg_out_rst: assert property (@(posedge core_clk)
    $rose(nrst) |-> ch2Cfg == '0)
    else $error("config settings output not zero after reset");

  a_rsvd_write_drop: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgWrite |=> ch2Config == ($past(regWrData) & 16'hfff7))
    else $error("config write not masked correctly");

  a_cfg_field_keep: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgWrite |=> ch2Config[15:4] == $past(regWrData[15:4]) && ch2Config[2:0] == $past(regWrData[2:0]))
    else $error("config write disturbed a field beside the reserved bit");

  a_cfg_read_back: assert property (@(posedge core_clk) disable iff (!nrst)
    s_cfgWriteThenRead |=> regRdData == ($past(regWrData, 3) & 16'hfff7))
    else $error("config read does not return the masked write");

  a_gain_high_word: assert property (@(posedge core_clk) disable iff (!nrst)
    s_gainHighWrite |-> ##2 calWords.chan2Gain[23:8] == $past(regWrData, 2))
    else $error("gain high word does not follow write");

  a_offset_low_byte: assert property (@(posedge core_clk) disable iff (!nrst)
    s_offsetLowWrite |-> ##2 calWords.chan2Offset[7:0] == $past(regWrData[15:8], 2))
    else $error("offset low byte does not follow write");

  a_rd_idle_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    !regRdStrobe |=> regRdData == 16'h0000)
    else $error("read data not zero outside the answer cycle");

  a_unmapped_rd_zero: assert property (@(posedge core_clk) disable iff (!nrst)
    regRdStrobe && !isMapped(regAddr) |=> regRdData == 16'h0000)
    else $error("unmapped index read nonzero");

endmodule

//--- verilog/adccc_pkg.sv
// Purpose: types of the calibration/config bank
// Assumes: nothing
// Notes: offsets and values live in adccc_regs.svh
package adccc_pkg;
  typedef enum logic [1:0] {
    ADCCC_IN_NORMAL,
    ADCCC_IN_SHORTED,
    ADCCC_IN_DC_DIAG,
    ADCCC_IN_AC_DIAG
  } adccc_input_sel_t;

  typedef struct packed {
    logic [9:0] chan2PhaseDelay;
    logic tempSensorSource;
    logic tempMeasureOn;
    logic tempInputInvert;
    adccc_input_sel_t chan2InputSelect;
  } adccc_ch2_config_t;

  typedef struct packed {
    logic [23:0] chan2Offset;
    logic [23:0] chan2Gain;
    logic [7:0] chan1GainLowByte;
  } adccc_cal_t;
endpackage

//--- verilog/adccc_regs.svh
// Purpose: register offsets, field positions and reset values of the calibration/config bank
// Assumes: 16-bit registers, word-indexed offsets
// Notes: definitions only
`ifndef ADCCC_REGS_SVH
`define ADCCC_REGS_SVH
`define ADCCC_ADDR_W 6
`define ADCCC_OFS_CH1_GAIN_LOW 6'h12
`define ADCCC_OFS_CH2_CONFIG 6'h13
`define ADCCC_OFS_CH2_OFFSET_HIGH 6'h14
`define ADCCC_OFS_CH2_OFFSET_LOW 6'h15
`define ADCCC_OFS_CH2_GAIN_HIGH 6'h16
`define ADCCC_OFS_CH2_GAIN_LOW 6'h17
`define ADCCC_RST_CH1_GAIN_LOW 16'h0000
`define ADCCC_RST_CH2_CONFIG 16'h0000
`define ADCCC_RST_CH2_OFFSET_HIGH 16'h0000
`define ADCCC_RST_CH2_OFFSET_LOW 16'h0000
`define ADCCC_RST_CH2_GAIN_HIGH 16'h8000
`define ADCCC_RST_CH2_GAIN_LOW 16'h0000
`define ADCCC_PHASE_MSB 15
`define ADCCC_PHASE_LSB 6
`define ADCCC_TSSRC_BIT 5
`define ADCCC_TSON_BIT 4
`define ADCCC_RSVD_BIT 3
`define ADCCC_TSINV_BIT 2
`define ADCCC_MUX_MSB 1
`define ADCCC_MUX_LSB 0
`define ADCCC_LOWBYTE_MSB 15
`define ADCCC_LOWBYTE_LSB 8
`endif
